// [mmst_pkg.sv]
// Constants and types of the management status and timing block
`default_nettype none
package mmst_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_KHZ       = 20000;
  localparam int unsigned T_INIT_MS     = 2000;
  localparam int unsigned T_WAKE_MS     = 300;
  localparam int unsigned T_RST_MIN_US  = 2;
  localparam logic [31:0] INIT_CYC_DEF  = 32'(T_INIT_MS * CLK_KHZ);
  localparam logic [31:0] WAKE_CYC_DEF  = 32'(T_WAKE_MS * CLK_KHZ);
  localparam logic [7:0]  RST_MIN_CYC   =
    8'((T_RST_MIN_US * CLK_KHZ + 999) / 1000);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_FLAGS     = 8'h04;
  localparam logic [7:0]  OFF_MASK      = 8'h08;
  localparam logic [7:0]  OFF_CTRL      = 8'h0c;
  localparam int unsigned ST_DNR_BIT    = 0;
  localparam int unsigned ST_LOWP_BIT   = 1;
  localparam int unsigned ST_BUSR_BIT   = 2;
  localparam int unsigned ST_FULL_BIT   = 3;
  localparam int unsigned FLG_READY_BIT = 0;
  localparam int unsigned CTL_PDOWN_BIT = 0;
  localparam int unsigned CTL_RATE_LSB  = 1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // Serial bus framing
  // ****************************************************************
  localparam logic [3:0]  RW_BIT_IDX    = 4'h7;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  typedef enum logic [2:0] {
    ST_INIT, ST_HELD, ST_RUN, ST_LOW, ST_WAKE
  } mmst_state_t;
endpackage : mmst_pkg
`default_nettype wire

// [mmst_core.sv]
// Management status, flag and power-state timing logic
`timescale 1ns/1ps
`default_nettype none
module mmst_core #(
  parameter int unsigned LANES    = 4,
  parameter int unsigned AUX_W    = 4,
  parameter int unsigned RS_W     = 2,
  parameter logic [31:0] INIT_CYC = mmst_pkg::INIT_CYC_DEF,
  parameter logic [31:0] WAKE_CYC = mmst_pkg::WAKE_CYC_DEF
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // AXI4-Lite write
  input  wire logic [mmst_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [mmst_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Module pins
  input  wire logic                        module_reset_n_pin,
  input  wire logic                        low_power_select_pin,
  input  wire logic                        scl_pin,
  input  wire logic                        sda_pin,
  output logic                             interrupt_request_n,
  // Monitored conditions
  input  wire logic [LANES-1:0]            rx_los_in,
  input  wire logic [LANES-1:0]            tx_fault_in,
  input  wire logic [AUX_W-1:0]            aux_cond_in,
  // Power, rate and bus-ready outputs
  output logic                             power_level1,
  output logic [RS_W-1:0]                  rate_select_out,
  output logic                             bus_ready
);
  localparam int unsigned FW = 1 + 2 * LANES + AUX_W;
  localparam int unsigned SW = 3 + FW;
  localparam int unsigned CW = 1 + RS_W;
  localparam logic [SW-1:0] SYNC_INIT = {3'h5, {(FW-1){1'b0}}, 1'b1};

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] prev_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= SYNC_INIT;
      sync2_r <= SYNC_INIT;
      prev_r  <= SYNC_INIT;
    end else begin
      sync1_r <= {module_reset_n_pin, low_power_select_pin, scl_pin,
                  aux_cond_in, tx_fault_in, rx_los_in, sda_pin};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  logic          rstn_s;
  logic          lp_s;
  logic          scl_s;
  logic          sda_s;
  logic [FW-2:0] cond_s;
  logic [FW-2:0] cond_p;
  assign rstn_s = sync2_r[SW-1];
  assign lp_s   = sync2_r[SW-2];
  assign scl_s  = sync2_r[SW-3];
  assign sda_s  = sync2_r[0];
  assign cond_s = sync2_r[FW-1:1];
  assign cond_p = prev_r[FW-1:1];

  // ****************************************************************
  // Serial bus transaction monitor
  // ****************************************************************
  logic       in_txn_r, in_txn_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic       rw_r, rw_nxt;
  logic       end_pend_r, end_pend_nxt;
  logic       end_rw_r, end_rw_nxt;
  logic       txn_rd_end;
  logic       txn_wr_end;
  logic       scl_fall, scl_rise, bus_start, bus_stop;

  always_comb begin
    scl_fall     = prev_r[SW-3] & ~scl_s;
    scl_rise     = ~prev_r[SW-3] & scl_s;
    bus_start    = scl_s & prev_r[SW-3] & prev_r[0] & ~sda_s;
    bus_stop     = scl_s & prev_r[SW-3] & ~prev_r[0] & sda_s;
    in_txn_nxt   = in_txn_r;
    bitcnt_nxt   = bitcnt_r;
    rw_nxt       = rw_r;
    end_pend_nxt = end_pend_r;
    end_rw_nxt   = end_rw_r;
    txn_rd_end   = 1'b0;
    txn_wr_end   = 1'b0;
    if (bus_start) begin
      in_txn_nxt = 1'b1;
      bitcnt_nxt = '0;
    end else if (bus_stop && in_txn_r) begin
      in_txn_nxt   = 1'b0;
      end_pend_nxt = 1'b1;
      end_rw_nxt   = rw_r;
    end else if (scl_rise && in_txn_r && bitcnt_r != mmst_pkg::BYTE_BITS) begin
      bitcnt_nxt = bitcnt_r + 4'h1;
      if (bitcnt_r == mmst_pkg::RW_BIT_IDX) begin
        rw_nxt = sda_s;
      end
    end
    // Timing reference: first clock fall after the stop
    if (end_pend_r && scl_fall) begin
      end_pend_nxt = 1'b0;
      txn_rd_end   = end_rw_r;
      txn_wr_end   = ~end_rw_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_txn_r   <= 1'b0;
      bitcnt_r   <= '0;
      rw_r       <= 1'b0;
      end_pend_r <= 1'b0;
      end_rw_r   <= 1'b0;
    end else begin
      in_txn_r   <= in_txn_nxt;
      bitcnt_r   <= bitcnt_nxt;
      rw_r       <= rw_nxt;
      end_pend_r <= end_pend_nxt;
      end_rw_r   <= end_rw_nxt;
    end
  end

  // ****************************************************************
  // Power state and initialisation timing
  // ****************************************************************
  mmst_pkg::mmst_state_t state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [7:0]  rlow_r, rlow_nxt;
  logic        dnr_r, dnr_nxt;
  logic        busr_r, busr_nxt;
  logic        lowp_r, lowp_nxt;
  logic        pin_reset;
  logic        ready_evt;
  logic        lp_req;
  logic [CW-1:0] ctrl_r;

  assign lp_req    = lp_s | ctrl_r[mmst_pkg::CTL_PDOWN_BIT];
  assign pin_reset = (rlow_r == mmst_pkg::RST_MIN_CYC);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 32'h1;
    dnr_nxt   = dnr_r;
    busr_nxt  = busr_r;
    ready_evt = 1'b0;
    lowp_nxt  = lp_req;
    rlow_nxt  = rlow_r;
    // Short low pulses are filtered out
    if (rstn_s) begin
      rlow_nxt = '0;
    end else if (!pin_reset) begin
      rlow_nxt = rlow_r + 8'h1;
    end
    if (pin_reset) begin
      state_nxt = mmst_pkg::ST_HELD;
      cnt_nxt   = '0;
      dnr_nxt   = 1'b1;
      busr_nxt  = 1'b0;
    end else begin
      case (state_r)
        mmst_pkg::ST_INIT: begin
          if (cnt_r == INIT_CYC - 32'h1) begin
            dnr_nxt   = 1'b0;
            busr_nxt  = 1'b1;
            ready_evt = 1'b1;
            state_nxt = lp_req ? mmst_pkg::ST_LOW : mmst_pkg::ST_RUN;
          end
        end
        mmst_pkg::ST_HELD: begin
          cnt_nxt = '0;
          if (rstn_s) begin
            state_nxt = mmst_pkg::ST_INIT;
          end
        end
        mmst_pkg::ST_RUN: begin
          if (lp_req) begin
            state_nxt = mmst_pkg::ST_LOW;
          end
        end
        mmst_pkg::ST_LOW: begin
          cnt_nxt = '0;
          if (!lp_req) begin
            state_nxt = mmst_pkg::ST_WAKE;
            dnr_nxt   = 1'b1;
          end
        end
        mmst_pkg::ST_WAKE: begin
          if (lp_req) begin
            state_nxt = mmst_pkg::ST_LOW;
          end else if (cnt_r == WAKE_CYC - 32'h1) begin
            dnr_nxt   = 1'b0;
            ready_evt = 1'b1;
            state_nxt = mmst_pkg::ST_RUN;
          end
        end
        default: state_nxt = mmst_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= mmst_pkg::ST_INIT;
      cnt_r   <= '0;
      rlow_r  <= '0;
      dnr_r   <= 1'b1;
      busr_r  <= 1'b0;
      lowp_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rlow_r  <= rlow_nxt;
      dnr_r   <= dnr_nxt;
      busr_r  <= busr_nxt;
      lowp_r  <= lowp_nxt;
    end
  end
  assign power_level1 = lowp_r;
  assign bus_ready    = busr_r;

  // ****************************************************************
  // Flags, masks, control and AXI4-Lite slave
  // ****************************************************************
  logic [FW-1:0]   flags_r, flags_nxt, mask_r, mask_nxt;
  logic [FW-1:0]   mask_sh_r, mask_sh_nxt, clr_r, clr_nxt, set_vec;
  logic [CW-1:0]   ctrl_nxt, ctrl_sh_r, ctrl_sh_nxt;
  logic            intr_n_r, intr_n_nxt;
  logic [RS_W-1:0] rate_r, rate_nxt;
  logic            aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
  logic [7:0]      awaddr_r, awaddr_nxt;
  logic [31:0]     wdata_r, wdata_nxt, wmask, wval, rdata_r, rdata_nxt;
  logic [3:0]      wstrb_r, wstrb_nxt;
  logic            awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic            bvalid_r, bvalid_nxt, arrdy_r, arrdy_nxt;
  logic            rvalid_r, rvalid_nxt;
  logic [1:0]      bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  assign set_vec = {cond_s & ~cond_p, ready_evt};

  always_comb begin
    flags_nxt   = flags_r;
    clr_nxt     = clr_r;
    mask_nxt    = mask_r;
    mask_sh_nxt = mask_sh_r;
    ctrl_nxt    = ctrl_r;
    ctrl_sh_nxt = ctrl_sh_r;
    aw_h_nxt    = aw_h_r | (s_axi_awvalid & awrdy_r);
    w_h_nxt     = w_h_r | (s_axi_wvalid & wrdy_r);
    awaddr_nxt  = (s_axi_awvalid & awrdy_r) ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = (s_axi_wvalid & wrdy_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt   = (s_axi_wvalid & wrdy_r) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt  = bvalid_r & ~s_axi_bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r & ~s_axi_rready;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}},
             {8{wstrb_r[0]}}};
    wval  = '0;
    // Clear on read lands at the read's timing reference; set wins
    if (txn_rd_end) begin
      flags_nxt = flags_r & ~clr_r;
      clr_nxt   = '0;
    end
    flags_nxt = flags_nxt | set_vec;
    if (txn_wr_end) begin
      mask_nxt = mask_sh_r;
      ctrl_nxt = ctrl_sh_r;
    end
    if (aw_h_r && w_h_r && !bvalid_r) begin
      aw_h_nxt   = 1'b0;
      w_h_nxt    = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = mmst_pkg::RESP_OKAY;
      if (awaddr_r == mmst_pkg::OFF_MASK) begin
        wval        = (32'(mask_sh_r) & ~wmask) | (wdata_r & wmask);
        mask_sh_nxt = wval[FW-1:0];
      end else if (awaddr_r == mmst_pkg::OFF_CTRL) begin
        wval        = (32'(ctrl_sh_r) & ~wmask) | (wdata_r & wmask);
        ctrl_sh_nxt = wval[CW-1:0];
      end else if (awaddr_r != mmst_pkg::OFF_STATUS &&
                   awaddr_r != mmst_pkg::OFF_FLAGS) begin
        bresp_nxt = mmst_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && arrdy_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mmst_pkg::RESP_OKAY;
      rdata_nxt  = '0;
      if (s_axi_araddr == mmst_pkg::OFF_STATUS) begin
        rdata_nxt[mmst_pkg::ST_DNR_BIT]  = dnr_r;
        rdata_nxt[mmst_pkg::ST_LOWP_BIT] = lowp_r;
        rdata_nxt[mmst_pkg::ST_BUSR_BIT] = busr_r;
        rdata_nxt[mmst_pkg::ST_FULL_BIT] = (state_r == mmst_pkg::ST_RUN);
      end else if (s_axi_araddr == mmst_pkg::OFF_FLAGS) begin
        rdata_nxt = 32'(flags_r);
        clr_nxt   = clr_nxt | flags_r;
      end else if (s_axi_araddr == mmst_pkg::OFF_MASK) begin
        rdata_nxt = 32'(mask_sh_r);
      end else if (s_axi_araddr == mmst_pkg::OFF_CTRL) begin
        rdata_nxt = 32'(ctrl_sh_r);
      end else begin
        rresp_nxt = mmst_pkg::RESP_SLVERR;
      end
    end
    if (pin_reset) begin
      flags_nxt   = '0;
      clr_nxt     = '0;
      mask_nxt    = '0;
      mask_sh_nxt = '0;
      ctrl_nxt    = '0;
      ctrl_sh_nxt = '0;
    end
    awrdy_nxt  = ~aw_h_nxt & ~bvalid_nxt;
    wrdy_nxt   = ~w_h_nxt & ~bvalid_nxt;
    arrdy_nxt  = ~rvalid_nxt;
    intr_n_nxt = ~|(flags_r & ~mask_r);
    rate_nxt   = ctrl_r[mmst_pkg::CTL_RATE_LSB +: RS_W];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r  <= '0;
      clr_r    <= '0;
      mask_r   <= '0;
      mask_sh_r <= '0;
      ctrl_r   <= '0;
      ctrl_sh_r <= '0;
      intr_n_r <= 1'b1;
      rate_r   <= '0;
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
      awrdy_r  <= 1'b0;
      wrdy_r   <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= '0;
      arrdy_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= '0;
    end else begin
      flags_r  <= flags_nxt;
      clr_r    <= clr_nxt;
      mask_r   <= mask_nxt;
      mask_sh_r <= mask_sh_nxt;
      ctrl_r   <= ctrl_nxt;
      ctrl_sh_r <= ctrl_sh_nxt;
      intr_n_r <= intr_n_nxt;
      rate_r   <= rate_nxt;
      aw_h_r   <= aw_h_nxt;
      w_h_r    <= w_h_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      awrdy_r  <= awrdy_nxt;
      wrdy_r   <= wrdy_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      arrdy_r  <= arrdy_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end
  assign interrupt_request_n = intr_n_r;
  assign rate_select_out     = rate_r;
  assign s_axi_awready       = awrdy_r;
  assign s_axi_wready        = wrdy_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arrdy_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The filter still reports a reset on the first cycle after the pin rises
  sequence s_held_release;
    state_r == mmst_pkg::ST_HELD && rstn_s && !pin_reset;
  endsequence
  sequence s_init_start;
    state_r == mmst_pkg::ST_INIT && cnt_r == 32'h0;
  endsequence

  a_reset_filter: assert property (
    state_r != mmst_pkg::ST_HELD ##1 state_r == mmst_pkg::ST_HELD
    |-> $past(rlow_r) == mmst_pkg::RST_MIN_CYC)
    else $error("held state entered without a long reset pulse");
  a_pin_release: assert property (
    s_held_release |=> s_init_start)
    else $error("init did not restart after reset pin release");
  a_init_done: assert property (
    state_r == mmst_pkg::ST_INIT && cnt_r == INIT_CYC - 32'h1 && !pin_reset
    |=> !dnr_r && busr_r && flags_r[mmst_pkg::FLG_READY_BIT])
    else $error("init end did not clear data-not-ready");
  a_ready_intr: assert property (
    ready_evt && !pin_reset && !mask_r[0] && !txn_wr_end
    |=> ##1 !interrupt_request_n)
    else $error("data ready did not raise the interrupt");
  a_low_power: assert property (
    lp_req |=> power_level1)
    else $error("low power not entered");
  a_wake_done: assert property (
    state_r == mmst_pkg::ST_WAKE && cnt_r == WAKE_CYC - 32'h1 &&
    !lp_req && !pin_reset |=> state_r == mmst_pkg::ST_RUN && !dnr_r)
    else $error("wake did not finish on time");
  a_flag_set: assert property (
    set_vec != '0 && !pin_reset |=> (flags_r & $past(set_vec)) ==
    $past(set_vec))
    else $error("condition did not set its flag");
  a_intr_assert: assert property (
    (flags_r & ~mask_r) != '0 |=> !interrupt_request_n)
    else $error("interrupt not asserted for pending flag");
  a_intr_release: assert property (
    (flags_r & ~mask_r) == '0 |=> interrupt_request_n)
    else $error("interrupt not released");
  a_clear_read: assert property (
    txn_rd_end && !pin_reset |=> (flags_r & $past(clr_r & ~set_vec)) == '0)
    else $error("read flags not cleared at read end");
  a_mask_commit: assert property (
    txn_wr_end && !pin_reset |=> mask_r == $past(mask_sh_r) &&
    ctrl_r == $past(ctrl_sh_r))
    else $error("write not committed at write end");
  a_rate_out: assert property (
    txn_wr_end && !pin_reset ##1 !pin_reset |=>
    rate_select_out == $past(ctrl_sh_r[mmst_pkg::CTL_RATE_LSB +: RS_W], 2))
    else $error("rate select output not updated");
endmodule : mmst_core
`default_nettype wire

// [mmst_host_model.sv]
// Two-wire host model that frames serial management transfers
`timescale 1ns/1ps
`default_nettype none
module mmst_host_model (
  // Serial bus lines, driven high by the model when idle
  output logic scl,
  output logic sda
);
  initial {scl, sda} = 2'h3;
  // Start, eight bits with direction last, acknowledge slot, stop, one fall
  task automatic frame(input logic rd);
    int i;
    // Lines move off the block's sampling edge
    #10 sda = 1'b0;
    for (i = 0; i < 9; i++) begin
      #200 scl = 1'b0;
      #100 sda = (i == 8) ? 1'b0 : ((i == 7) ? rd : i[0]);
      #100 scl = 1'b1;
    end
    #100 sda = 1'b1;
    #100 scl = 1'b0;
    #200 scl = 1'b1;
  endtask
endmodule // mmst_host_model
`default_nettype wire

// [tb_mmst_core.sv]
// Self-checking testbench of the management status and timing block
`timescale 1ns/1ps
`default_nettype none
module tb_mmst_core;
  // ************************************************************
  // Harness
  // ************************************************************
  logic        clk, rst, awv, wv, bready, arv, rready, rst_pin_n, lp_pin;
  logic        awready, wready, bvalid, arready, rvalid, scl, sda;
  logic        irq_n, plv1, bus_rdy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, rate, rsel;
  logic [11:0] cv;
  logic [3:0]  strb;
  logic [2:0]  obs;
  int          fail_count, n_compared, cyc, k, kind, lane;
  assign obs = {bus_rdy, plv1, irq_n};
  mmst_core #(.INIT_CYC(32'h000000c8), .WAKE_CYC(32'h00000064)) mmst_core_i (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_reset_n_pin(rst_pin_n), .low_power_select_pin(lp_pin),
    .scl_pin(scl), .sda_pin(sda), .interrupt_request_n(irq_n),
    .rx_los_in(cv[3:0]), .tx_fault_in(cv[7:4]), .aux_cond_in(cv[11:8]),
    .power_level1(plv1), .rate_select_out(rate), .bus_ready(bus_rdy));
  mmst_host_model mmst_host_model_i (.scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits up to n cycles for an observed pin level, then compares it
  task automatic wt(input int idx, input logic v, input int n);
    for (k = 0; k < n && obs[idx] !== v; k++) @(posedge clk);
    chk32({31'h0, obs[idx]}, {31'h0, v});
  endtask
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awv, wv, bready} <= {3{wr}};
    {arv, rready} <= {2{!wr}};
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (arready) arv <= 1'b0;
    end while (!(bvalid && bready) && !(rvalid && rready));
    {bready, rready} <= 2'h0;
    rd = rdata;
    rs = wr ? bresp : rresp;
  endtask
  function automatic logic [31:0] fb(input int kd, input int ln);
    return 32'h1 << (1 + 4 * kd + ln);
  endfunction
  // Mask register after a byte-strobed write over an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((old & ~m) | (nw & m)) & 32'h00001fff;
  endfunction
  task automatic clr(input logic [31:0] e);
    ax(1'b0, mmst_pkg::OFF_FLAGS, 32'h0);
    chk32(rd, e);
    wt(0, 1'b0, 0);
    mmst_host_model_i.frame(1'b1);
    wt(0, 1'b1, 10);
  endtask
  task automatic wake(input int n);
    logic [31:0] e;
    e = 32'h1 << mmst_pkg::ST_BUSR_BIT | 32'h1 << mmst_pkg::ST_FULL_BIT;
    wt(0, 1'b0, n);
    ax(1'b0, mmst_pkg::OFF_STATUS, 32'h0);
    chk32(rd, e);
    clr(32'h1 << mmst_pkg::FLG_READY_BIT);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_pin_n <= 1'b1;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {rst, rst_pin_n} = 2'h3;
    {awv, wv, bready, arv, rready, lp_pin} = '0;
    {awaddr, araddr, wdata, cv} = '0;
    strb = 4'hf;
    {fail_count, n_compared, cyc} = '0;
    k = $urandom(56926);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wt(2, 1'b1, 260);
    wake(10);
    for (kind = 0; kind < 3; kind++) begin
      lane = $urandom_range(3);
      @(posedge clk);
      cv <= 12'h1 << (4 * kind + lane);
      wt(0, 1'b0, 10);
      @(posedge clk);
      cv <= '0;
      clr(fb(kind, lane));
    end
    ax(1'b1, mmst_pkg::OFF_MASK, 32'h00001fff);
    mmst_host_model_i.frame(1'b0);
    @(posedge clk);
    cv <= 12'h010 << lane;
    repeat (12) @(posedge clk);
    wt(0, 1'b1, 0);
    cv <= '0;
    ax(1'b1, mmst_pkg::OFF_MASK, 32'h0);
    wt(0, 1'b1, 0);
    mmst_host_model_i.frame(1'b0);
    wt(0, 1'b0, 10);
    clr(fb(1, lane));
    rsel = 2'($urandom_range(3, 1));
    ax(1'b1, mmst_pkg::OFF_CTRL, {29'h0, rsel, 1'b1});
    mmst_host_model_i.frame(1'b0);
    wt(1, 1'b1, 10);
    chk32({30'h0, rate}, {30'h0, rsel});
    ax(1'b1, mmst_pkg::OFF_CTRL, {29'h0, rsel, 1'b0});
    mmst_host_model_i.frame(1'b0);
    wt(1, 1'b0, 10);
    wake(130);
    @(posedge clk);
    lp_pin <= 1'b1;
    wt(1, 1'b1, 10);
    @(posedge clk);
    lp_pin <= 1'b0;
    wt(1, 1'b0, 10);
    wake(130);
    k = $urandom_range(8191);
    ax(1'b1, mmst_pkg::OFF_MASK, 32'(k));
    chk32({30'h0, rs}, {30'h0, mmst_pkg::RESP_OKAY});
    ax(1'b0, mmst_pkg::OFF_MASK, 32'h0);
    chk32(rd, 32'(k));
    strb <= 4'($urandom_range(15));
    ax(1'b1, mmst_pkg::OFF_MASK, ~32'(k));
    ax(1'b0, mmst_pkg::OFF_MASK, 32'h0);
    chk32(rd, merge(32'(k), ~32'(k), strb));
    strb <= 4'hf;
    ax(1'b1, 8'h10, 32'h0);
    chk32({30'h0, rs}, {30'h0, mmst_pkg::RESP_SLVERR});
    ax(1'b0, 8'h10, 32'h0);
    chk32({30'h0, rs}, {30'h0, mmst_pkg::RESP_SLVERR});
    pulse(20);
    wt(2, 1'b1, 0);
    pulse(60);
    wt(2, 1'b0, 0);
    wt(2, 1'b1, 260);
    wake(10);
    complete_run();
  end
endmodule // tb_mmst_core
`default_nettype wire
